// File: rtl/pld_consts.svh
// constants for the loop lock detect and holdover block
// ----------------------------------------------------------------------------
// Notes on behaviour
// - each loop counts comparisons whose phase error is inside the window
// - lock indication rises when the count reaches that loop's threshold
// - one out-of-window comparison drops a held lock at once, except loop2's during holdover
// - each status pin can show loop1 lock, loop2 lock, or both
// - holdover works only when holdover enable is one
// - fixed tune select one drives the fixed code during holdover
// - fixed select zero with tracking drives the last tracked code
// - tune-acquired flag sets after tracking captures; selectable on pins
// - tracked code updates once per multiplier times counter loop1 cycles
// - the tracked code is readable as a read-back value
// - holdover entry puts loop1 charge pump into high impedance
// - holdover drops loop1 lock and raises holdover status
// - loop2 lock held before holdover stays asserted through holdover
// - loop1 keeps trying to lock during holdover
// - holdover status is selectable on either status pin
// - holdover ends by host command or when input-missing clears
// - loop1 lock may serve as the holdover exit criterion
// - exit mode zero exits on input-missing clearing
// - input pick field of 3 forces holdover; exit re-locks to pick
// ----------------------------------------------------------------------------
`ifndef PLD_CONSTS_SVH
`define PLD_CONSTS_SVH

`define PLD_CNT_W      14
`define PLD_TUNE_W     10
`define PLD_MULT_W     15
`define PLD_CNTR_W     8
`define PLD_CNT_ZERO   14'h0000
`define PLD_TUNE_ZERO  10'h000
`define PLD_TUNE_MID   10'h200
`define PLD_ACQ_UPDATES 4'h4
`define PLD_PICK_HOLD  2'h3
`define PLD_PICK_ZERO  2'h0
`define PLD_ACQ_ZERO   4'h0
`define PLD_ACQ_STEP   4'h1
`define PLD_SEL_W      3

`endif

// File: rtl/pld_pkg.sv
// types for the loop lock detect and holdover block
package pld_pkg;
  typedef enum logic [2:0]
  {
    PLD_SEL_LOW   = 3'h0,
    PLD_SEL_LOCK1 = 3'h1,
    PLD_SEL_LOCK2 = 3'h2,
    PLD_SEL_BOTH  = 3'h3,
    PLD_SEL_HOLD  = 3'h4,
    PLD_SEL_ACQ   = 3'h5
  } pld_sel_t;

  typedef enum logic [0:0]
  {
    PLD_ST_RUN  = 1'b0,
    PLD_ST_HOLD = 1'b1
  } pld_state_t;
endpackage

// File: rtl/pld_lock_det.sv
// digital lock detector for one loop
`timescale 1ns/100ps
`include "pld_consts.svh"
module pld_lock_det
(
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // comparison result
  input  wire logic                   cmp_valid,
  input  wire logic                   cmp_in_window,
  input  wire logic [`PLD_CNT_W-1:0]  lock_threshold,
  // result
  output logic                        locked
);
  import pld_pkg::*;

  logic [`PLD_CNT_W-1:0] count_reg;
  logic                  locked_reg;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      count_reg <= `PLD_CNT_ZERO;
    else if (cmp_valid && !cmp_in_window)
      count_reg <= `PLD_CNT_ZERO;
    else if (cmp_valid && count_reg != lock_threshold)
      count_reg <= count_reg + `PLD_CNT_W'(1);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      locked_reg <= 1'b0;
    else if (cmp_valid && !cmp_in_window)
      locked_reg <= 1'b0;
    else if (cmp_valid && count_reg + `PLD_CNT_W'(1) >= lock_threshold)
      locked_reg <= 1'b1;
  end

  assign locked = locked_reg;
endmodule

// File: rtl/pld_rate_div.sv
// tracked tune update rate divider, multiplier times counter
`timescale 1ns/100ps
`include "pld_consts.svh"
module pld_rate_div
(
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // loop1 comparison strobe and rate fields
  input  wire logic                   tick,
  input  wire logic [`PLD_MULT_W-1:0] rate_mult,
  input  wire logic [`PLD_CNTR_W-1:0] rate_cntr,
  // one-cycle update enable
  output logic                        update
);
  import pld_pkg::*;

  logic [`PLD_MULT_W-1:0] mult_reg;
  logic [`PLD_CNTR_W-1:0] cntr_reg;
  logic                   mult_wrap;
  logic                   cntr_wrap;

  // zero fields behave as one so the divider never stalls
  assign mult_wrap = (mult_reg + `PLD_MULT_W'(1) >= rate_mult);
  assign cntr_wrap = (cntr_reg + `PLD_CNTR_W'(1) >= rate_cntr);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      mult_reg <= '0;
    else if (tick)
      mult_reg <= mult_wrap ? '0 : mult_reg + `PLD_MULT_W'(1);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cntr_reg <= '0;
    else if (tick && mult_wrap)
      cntr_reg <= cntr_wrap ? '0 : cntr_reg + `PLD_CNTR_W'(1);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      update <= 1'b0;
    else
      update <= tick && mult_wrap && cntr_wrap;
  end
endmodule

// File: rtl/pld_top.sv
// lock detect for both loops and loop1 holdover control
`timescale 1ns/100ps
`include "pld_consts.svh"
module pld_top
(
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // phase comparison results, one-cycle strobes from comparators
  input  wire logic                   loop1_cmp_valid,
  input  wire logic                   loop1_cmp_in_window,
  input  wire logic                   loop2_cmp_valid,
  input  wire logic                   loop2_cmp_in_window,
  // present loop1 tuning code from the tracking converter
  input  wire logic [`PLD_TUNE_W-1:0] loop1_tune_sense,
  // input-missing flag, asynchronous pin level
  input  wire logic                   input_missing_flag,
  // settings
  input  wire logic [`PLD_CNT_W-1:0]  loop1_lock_threshold,
  input  wire logic [`PLD_CNT_W-1:0]  loop2_lock_threshold,
  input  wire pld_pkg::pld_sel_t      status_a_select,
  input  wire pld_pkg::pld_sel_t      status_b_select,
  input  wire logic                   holdover_enable,
  input  wire logic                   track_enable,
  input  wire logic                   fixed_tune_select,
  input  wire logic [`PLD_TUNE_W-1:0] fixed_tune_code,
  input  wire logic [`PLD_MULT_W-1:0] tune_rate_multiplier,
  input  wire logic [`PLD_CNTR_W-1:0] tune_rate_counter,
  input  wire logic                   holdover_exit_on_lock,
  input  wire logic                   holdover_force,
  input  wire logic [1:0]             input_pick_field,
  // status
  output logic                        status_pin_a,
  output logic                        status_pin_b,
  output logic                        loop1_locked,
  output logic                        loop2_locked,
  output logic                        holdover_status,
  output logic                        tune_acquired,
  output logic [`PLD_TUNE_W-1:0]      tune_code_readback,
  // loop1 drive
  output logic                        loop1_pump_hiz,
  output logic                        loop1_tune_drive_en,
  output logic [`PLD_TUNE_W-1:0]      loop1_tune_pin,
  output logic [1:0]                  loop1_input_pick
);
  import pld_pkg::*;

  // --------------------------------------------------------------------------
  // input synchronisation
  // --------------------------------------------------------------------------
  logic missing_meta_reg;
  logic missing_reg;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      missing_meta_reg <= 1'b0;
      missing_reg      <= 1'b0;
    end
    else
    begin
      missing_meta_reg <= input_missing_flag;
      missing_reg      <= missing_meta_reg;
    end
  end

  logic missing_prev_reg;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      missing_prev_reg <= 1'b0;
    else
      missing_prev_reg <= missing_reg;
  end

  // --------------------------------------------------------------------------
  // lock detectors
  // --------------------------------------------------------------------------
  logic lock1_raw;
  logic lock2_raw;

  // loop1 keeps comparing in holdover so lock may be re-acquired
  pld_lock_det u_lock1
  (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .cmp_valid      (loop1_cmp_valid),
    .cmp_in_window  (loop1_cmp_in_window),
    .lock_threshold (loop1_lock_threshold),
    .locked         (lock1_raw)
  );

  pld_lock_det u_lock2
  (
    .mclk           (mclk),
    .rst_n          (rst_n),
    .cmp_valid      (loop2_cmp_valid),
    .cmp_in_window  (loop2_cmp_in_window),
    .lock_threshold (loop2_lock_threshold),
    .locked         (lock2_raw)
  );

  // --------------------------------------------------------------------------
  // holdover state
  // --------------------------------------------------------------------------
  pld_state_t state_reg;
  pld_state_t state_next;
  logic       enter_req;
  logic       exit_req;
  logic       lock1_prev_reg;
  logic       pick_forced;

  assign pick_forced = (input_pick_field == `PLD_PICK_HOLD);

  // entry on host force, pick field 3, or input going missing
  assign enter_req = holdover_enable &&
                     (holdover_force || pick_forced ||
                      (missing_reg && !missing_prev_reg));

  // automatic exit: missing clears, or loop1 lock regained
  // a held force or pick of 3 blocks both exits; only clearing holdover_enable ends holdover then
  always_comb
  begin
    exit_req = 1'b0;
    if (!holdover_enable || (!holdover_force && !pick_forced &&
                             missing_prev_reg && !missing_reg && !holdover_exit_on_lock))
      exit_req = 1'b1;
    if (holdover_exit_on_lock && !holdover_force && !pick_forced &&
        !missing_reg && lock1_raw && !lock1_prev_reg)
      exit_req = 1'b1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      lock1_prev_reg <= 1'b0;
    else
      lock1_prev_reg <= lock1_raw;
  end

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      PLD_ST_RUN:
        if (enter_req)
          state_next = PLD_ST_HOLD;
      PLD_ST_HOLD:
        if (exit_req)
          state_next = PLD_ST_RUN;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      state_reg <= PLD_ST_RUN;
    else
      state_reg <= state_next;
  end

  // last chosen real input kept so exit re-locks to it
  logic [1:0] pick_last_reg;

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      pick_last_reg <= `PLD_PICK_ZERO;
    else if (!pick_forced)
      pick_last_reg <= input_pick_field;
  end

  // --------------------------------------------------------------------------
  // tracking of loop1 tune code
  // --------------------------------------------------------------------------
  logic                   update_en;
  logic [`PLD_TUNE_W-1:0] track_reg;
  logic [3:0]             acq_cnt_reg;
  logic                   acquired_reg;
  logic                   in_hold;

  assign in_hold = (state_reg == PLD_ST_HOLD);

  pld_rate_div u_rate
  (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .tick      (loop1_cmp_valid),
    .rate_mult (tune_rate_multiplier),
    .rate_cntr (tune_rate_counter),
    .update    (update_en)
  );

  // frozen in holdover so the code stays at the last good value
  // the entry edge is frozen too, so the held code predates the event
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      track_reg <= `PLD_TUNE_MID;
    else if (track_enable && state_next != PLD_ST_HOLD && update_en)
      track_reg <= loop1_tune_sense;
  end

  // acquired after a few updates; tracking error settles within them
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      acq_cnt_reg <= `PLD_ACQ_ZERO;
    else if (!track_enable)
      acq_cnt_reg <= `PLD_ACQ_ZERO;
    else if (update_en && !in_hold && acq_cnt_reg != `PLD_ACQ_UPDATES)
      acq_cnt_reg <= acq_cnt_reg + `PLD_ACQ_STEP;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      acquired_reg <= 1'b0;
    else
      acquired_reg <= track_enable && (acq_cnt_reg == `PLD_ACQ_UPDATES);
  end

  // --------------------------------------------------------------------------
  // status functions and outputs
  // --------------------------------------------------------------------------
  logic lock1_eff;
  logic lock2_eff;
  logic lock2_held_reg;

  // loop2 lock at holdover entry is held until exit
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      lock2_held_reg <= 1'b0;
    else if (state_reg == PLD_ST_RUN && state_next == PLD_ST_HOLD)
      lock2_held_reg <= lock2_raw;
    else if (!in_hold)
      lock2_held_reg <= 1'b0;
  end

  // next state used so lock drops on the edge that holdover shows
  assign lock1_eff = lock1_raw && (state_next != PLD_ST_HOLD);
  assign lock2_eff = lock2_raw || lock2_held_reg;

  function automatic logic pick_status(input pld_sel_t sel, input logic l1,
                                       input logic l2, input logic hold,
                                       input logic acq);
    logic r;
    r = 1'b0;
    unique case (sel)
      PLD_SEL_LOW:   r = 1'b0;
      PLD_SEL_LOCK1: r = l1;
      PLD_SEL_LOCK2: r = l2;
      PLD_SEL_BOTH:  r = l1 && l2;
      PLD_SEL_HOLD:  r = hold;
      PLD_SEL_ACQ:   r = acq;
      default:       r = 1'b0;
    endcase
    return r;
  endfunction

  logic hold_now;
  assign hold_now = (state_next == PLD_ST_HOLD);

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      status_pin_a <= 1'b0;
      status_pin_b <= 1'b0;
    end
    else
    begin
      status_pin_a <= pick_status(status_a_select, lock1_eff, lock2_eff,
                                  hold_now, acquired_reg);
      status_pin_b <= pick_status(status_b_select, lock1_eff, lock2_eff,
                                  hold_now, acquired_reg);
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      loop1_locked    <= 1'b0;
      loop2_locked    <= 1'b0;
      holdover_status <= 1'b0;
      tune_acquired   <= 1'b0;
    end
    else
    begin
      loop1_locked    <= lock1_eff;
      loop2_locked    <= lock2_eff;
      holdover_status <= hold_now;
      tune_acquired   <= acquired_reg;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      tune_code_readback <= `PLD_TUNE_MID;
    else
      tune_code_readback <= track_reg;
  end

  // --------------------------------------------------------------------------
  // loop1 drive in holdover
  // --------------------------------------------------------------------------
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      loop1_pump_hiz      <= 1'b0;
      loop1_tune_drive_en <= 1'b0;
      loop1_tune_pin      <= `PLD_TUNE_ZERO;
    end
    else
    begin
      loop1_pump_hiz      <= hold_now;
      loop1_tune_drive_en <= hold_now;
      // code kept current outside holdover so entry needs no settling
      if (fixed_tune_select)
        loop1_tune_pin <= fixed_tune_code;
      else if (track_enable)
        loop1_tune_pin <= track_reg;
      else
        loop1_tune_pin <= fixed_tune_code;
    end
  end

  // pick 3 is no real input, so the loop is shown the last real one
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      loop1_input_pick <= `PLD_PICK_ZERO;
    else
      loop1_input_pick <= pick_forced ? pick_last_reg : input_pick_field;
  end
endmodule

// File: dv/pld_host_model.sv
// far-side model: comparator strobes and host rate settings
`timescale 1ns/100ps
`include "pld_consts.svh"
module pld_host_model
(
  // clock
  input  wire logic                   mclk,
  // strobe control from the bench
  input  wire logic                   run,
  input  wire logic                   win,
  // toward the block
  output logic                        cmp_valid = 1'b0,
  output logic                        cmp_in_window = 1'b0,
  output logic [`PLD_MULT_W-1:0]      rate_mult,
  output logic [`PLD_CNTR_W-1:0]      rate_cntr
);
  logic flip = 1'b0;

  // strobes every 20 ns, so 25 x 20 gives 100 kHz updates
  assign rate_mult = 15'h0019;
  assign rate_cntr = 8'h14;

  always @(negedge mclk)
  begin
    flip          <= ~flip;
    cmp_valid     <= run;
    // window bit is junk between strobes, never a stale copy
    cmp_in_window <= run ? win : flip;
  end
endmodule

// File: dv/pld_top_sva.sv
// checker for lock detect and holdover at the top ports
`timescale 1ns/100ps
`include "pld_consts.svh"
module pld_top_sva
(
  // clock and reset
  input wire logic                   mclk,
  input wire logic                   rst_n,
  // inputs watched
  input wire logic                   loop1_cmp_valid,
  input wire logic                   loop1_cmp_in_window,
  input wire logic                   loop2_cmp_valid,
  input wire logic                   loop2_cmp_in_window,
  input wire logic                   holdover_enable,
  input wire logic                   fixed_tune_select,
  input wire logic [`PLD_TUNE_W-1:0] fixed_tune_code,
  input wire pld_pkg::pld_sel_t      status_b_select,
  // outputs watched
  input wire logic                   status_pin_b,
  input wire logic                   loop1_locked,
  input wire logic                   loop2_locked,
  input wire logic                   holdover_status,
  input wire logic                   tune_acquired,
  input wire logic [`PLD_TUNE_W-1:0] tune_code_readback,
  input wire logic                   loop1_pump_hiz,
  input wire logic                   loop1_tune_drive_en,
  input wire logic [`PLD_TUNE_W-1:0] loop1_tune_pin
);
  import pld_pkg::*;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  miss_drops_lock1_a: assert property (
    loop1_cmp_valid && !loop1_cmp_in_window |-> ##2 !loop1_locked)
    else $error("loop1 lock held after a miss");
  miss_drops_lock2_a: assert property (
    loop2_cmp_valid && !loop2_cmp_in_window && !holdover_status
      |-> ##2 (!loop2_locked || holdover_status))
    else $error("loop2 lock held after a miss");
  lock_needs_hit_a: assert property (
    $rose(loop2_locked) |-> $past(loop2_cmp_valid && loop2_cmp_in_window, 2))
    else $error("loop2 lock rose without an in-window strobe");
  hold_drops_lock_a: assert property (
    holdover_status |-> !loop1_locked)
    else $error("loop1 lock shown during holdover");
  hold_opens_loop_a: assert property (
    loop1_pump_hiz == holdover_status && loop1_tune_drive_en == holdover_status)
    else $error("pump or tune drive disagrees with holdover");
  hold_needs_enable_a: assert property (
    !holdover_enable [*4] |-> !holdover_status)
    else $error("holdover while disabled");
  fixed_code_out_a: assert property (
    holdover_status && $past(holdover_status) && $past(fixed_tune_select)
      |-> loop1_tune_pin == $past(fixed_tune_code))
    else $error("fixed tune code not driven");
  track_frozen_a: assert property (
    holdover_status && $past(holdover_status) |-> $stable(tune_code_readback))
    else $error("tracked code moved during holdover");
  pin_low_sel_a: assert property (
    $past(status_b_select) == PLD_SEL_LOW |-> !status_pin_b)
    else $error("status pin b high on low select");

  cover property ($rose(loop1_locked));
  cover property ($rose(holdover_status));
  cover property ($rose(tune_acquired));
endmodule

// File: dv/pld_top_bench.sv
// self-checking bench for lock detect and holdover
`timescale 1ns/100ps
`include "pld_consts.svh"
module pld_top_bench;
  import pld_pkg::*;
  logic                   mclk = 1'b0, rst_n = 1'b0;
  logic                   run1 = 1'b0, win1 = 1'b1, run2 = 1'b0, win2 = 1'b1;
  logic                   loop1_cmp_valid, loop1_cmp_in_window;
  logic                   loop2_cmp_valid, loop2_cmp_in_window;
  logic [`PLD_TUNE_W-1:0] loop1_tune_sense = 10'h155, fixed_tune_code = 10'h2A5;
  logic                   input_missing_flag = 1'b0, holdover_enable = 1'b1;
  logic [`PLD_CNT_W-1:0]  loop1_lock_threshold = 14'h0005, loop2_lock_threshold = 14'h0003;
  pld_sel_t               status_a_select = PLD_SEL_LOW, status_b_select = PLD_SEL_LOW;
  logic                   track_enable = 1'b1, fixed_tune_select = 1'b0;
  logic [`PLD_MULT_W-1:0] tune_rate_multiplier;
  logic [`PLD_CNTR_W-1:0] tune_rate_counter;
  logic                   holdover_exit_on_lock = 1'b0, holdover_force = 1'b0;
  logic [1:0]             input_pick_field = 2'h2, loop1_input_pick;
  logic                   status_pin_a, status_pin_b, loop1_locked, loop2_locked;
  logic                   holdover_status, tune_acquired, loop1_pump_hiz, loop1_tune_drive_en;
  logic [`PLD_TUNE_W-1:0] tune_code_readback, loop1_tune_pin;
  int                     bad_count = 0, checked = 0;
  // {select, expected pin} with loop1 locked, loop2 not, acquired set
  logic [3:0]             rows [8] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h8, 4'hB, 4'hC, 4'hE};

  always #10 mclk = ~mclk;

  pld_host_model host1 (.mclk, .run(run1), .win(win1), .cmp_valid(loop1_cmp_valid),
    .cmp_in_window(loop1_cmp_in_window), .rate_mult(tune_rate_multiplier),
    .rate_cntr(tune_rate_counter));
  pld_host_model host2 (.mclk, .run(run2), .win(win2), .cmp_valid(loop2_cmp_valid),
    .cmp_in_window(loop2_cmp_in_window), .rate_mult(), .rate_cntr());

  pld_top uut (.mclk, .rst_n, .loop1_cmp_valid, .loop1_cmp_in_window, .loop2_cmp_valid,
    .loop2_cmp_in_window, .loop1_tune_sense, .input_missing_flag, .loop1_lock_threshold,
    .loop2_lock_threshold, .status_a_select, .status_b_select, .holdover_enable,
    .track_enable, .fixed_tune_select, .fixed_tune_code, .tune_rate_multiplier,
    .tune_rate_counter, .holdover_exit_on_lock, .holdover_force, .input_pick_field,
    .status_pin_a, .status_pin_b, .loop1_locked, .loop2_locked, .holdover_status,
    .tune_acquired, .tune_code_readback, .loop1_pump_hiz, .loop1_tune_drive_en,
    .loop1_tune_pin, .loop1_input_pick);

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic conclude;
    if (bad_count == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // holdover entry and exit latency is a few cycles, bounded here
  task automatic wait_hold(input logic want);
    for (int i = 0; i < 40 && holdover_status !== want; i++)
      @(negedge mclk);
  endtask

  initial
  begin
    #300000;
    bad_count++;
    conclude();
  end

  initial
  begin
    repeat (4) @(negedge mclk);
    chk(tune_code_readback, 10'h200);
    rst_n <= 1'b1;
    run1  <= 1'b1;
    run2  <= 1'b1;
    repeat (4) @(negedge mclk);
    chk(loop2_locked, 1'b0);
    @(negedge mclk);
    chk(loop2_locked, 1'b1);
    @(negedge mclk);
    chk(loop1_locked, 1'b0);
    @(negedge mclk);
    chk(loop1_locked, 1'b1);
    // one miss, then a full fresh run is needed
    win1 <= 1'b0;
    @(negedge mclk);
    win1 <= 1'b1;
    repeat (2) @(negedge mclk);
    chk(loop1_locked, 1'b0);
    repeat (4) @(negedge mclk);
    chk(loop1_locked, 1'b0);
    @(negedge mclk);
    chk(loop1_locked, 1'b1);
    for (int i = 0; i < 3000 && tune_acquired !== 1'b1; i++)
      @(negedge mclk);
    chk(tune_acquired, 1'b1);
    chk(tune_code_readback, 10'h155);
    win2 <= 1'b0;
    @(negedge mclk);
    win2 <= 1'b1;
    run2 <= 1'b0;
    repeat (3) @(negedge mclk);
    foreach (rows[i])
    begin
      status_a_select <= pld_sel_t'(rows[i][3:1]);
      status_b_select <= pld_sel_t'(rows[7-i][3:1]);
      repeat (2) @(negedge mclk);
      chk(status_pin_a, rows[i][0]);
      chk(status_pin_b, rows[7-i][0]);
    end
    run2 <= 1'b1;
    repeat (6) @(negedge mclk);
    // fixed code while tracking stays on
    status_a_select   <= PLD_SEL_HOLD;
    status_b_select   <= PLD_SEL_LOCK2;
    fixed_tune_select <= 1'b1;
    holdover_force    <= 1'b1;
    repeat (3) @(negedge mclk);
    chk(holdover_status, 1'b1);
    chk(loop1_pump_hiz, 1'b1);
    chk(loop1_locked, 1'b0);
    chk(loop1_tune_pin, 10'h2A5);
    chk(status_pin_a, 1'b1);
    chk(status_pin_b, 1'b1);
    // loop2 miss inside holdover must not drop its held lock
    win2 <= 1'b0;
    @(negedge mclk);
    win2 <= 1'b1;
    repeat (3) @(negedge mclk);
    chk(loop2_locked, 1'b1);
    holdover_force     <= 1'b0;
    input_missing_flag <= 1'b1;
    repeat (4) @(negedge mclk);
    input_missing_flag <= 1'b0;
    wait_hold(1'b0);
    chk(holdover_status, 1'b0);
    // tracked code, entered on input loss
    fixed_tune_select  <= 1'b0;
    input_missing_flag <= 1'b1;
    wait_hold(1'b1);
    loop1_tune_sense <= 10'h0AA;
    repeat (3) @(negedge mclk);
    chk(loop1_tune_pin, 10'h155);
    chk(tune_code_readback, 10'h155);
    input_missing_flag <= 1'b0;
    wait_hold(1'b0);
    chk(holdover_status, 1'b0);
    input_pick_field <= 2'h3;
    repeat (3) @(negedge mclk);
    chk(holdover_status, 1'b1);
    chk(loop1_input_pick, 2'h2);
    holdover_enable <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(holdover_status, 1'b0);
    input_pick_field <= 2'h1;
    holdover_force   <= 1'b1;
    repeat (5) @(negedge mclk);
    chk(holdover_status, 1'b0);
    chk(loop1_input_pick, 2'h1);
    holdover_force        <= 1'b0;
    holdover_enable       <= 1'b1;
    holdover_exit_on_lock <= 1'b1;
    input_missing_flag    <= 1'b1;
    wait_hold(1'b1);
    input_missing_flag <= 1'b0;
    repeat (6) @(negedge mclk);
    chk(holdover_status, 1'b1);
    win1 <= 1'b0;
    @(negedge mclk);
    win1 <= 1'b1;
    wait_hold(1'b0);
    chk(holdover_status, 1'b0);
    // tracking off: acquired clears, pin falls back to the fixed code
    track_enable <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(tune_acquired, 1'b0);
    chk(loop1_tune_pin, 10'h2A5);
    // reset in mid-run, then a fresh lock from the first edge after release
    rst_n <= 1'b0;
    repeat (2) @(negedge mclk);
    chk(tune_code_readback, 10'h200);
    chk(loop1_locked, 1'b0);
    chk(holdover_status, 1'b0);
    rst_n <= 1'b1;
    repeat (5) @(negedge mclk);
    chk(loop1_locked, 1'b0);
    @(negedge mclk);
    chk(loop1_locked, 1'b1);
    conclude();
  end
endmodule

bind pld_top pld_top_sva chk_i (.mclk, .rst_n, .loop1_cmp_valid, .loop1_cmp_in_window,
  .loop2_cmp_valid, .loop2_cmp_in_window, .holdover_enable, .fixed_tune_select,
  .fixed_tune_code, .status_b_select, .status_pin_b, .loop1_locked, .loop2_locked,
  .holdover_status, .tune_acquired, .tune_code_readback, .loop1_pump_hiz,
  .loop1_tune_drive_en, .loop1_tune_pin);
